// ===== arcp_pkg.sv
// What this block does
// - convert two 24-bit channels, as a stereo pair or two mono channels
// - converted output is two 24-bit words, left aligned in their containers
// - decimate both one-bit density streams to 24-bit words for either output path
// - software input registers: bits 31..8 feed converter bits 23..0, low byte ignored
// - route select picks converter input: audio interface or software input registers
// - results readable in two output registers and routed toward the PCM port
// - separate input and output converters, each with its own auto mode bit
// - manual mode takes rate from the programmable rate register, rewritable anytime
// - manual mode raises the conversion interrupt at the programmed rate
// - automatic mode follows the applied frame sync
// - automatic output feeding the CPU is paced by main frame counter, 8-192 kHz
// - each converter pulses an edge interrupt after conversion, no clearing needed
// - each data register holds one sample only; one transfer per register per interrupt
// - the single-sample registers raise DMA requests
// - converter sample rates supported from 62.5 kHz up to 12.5 MHz
// - density interface drives one shared clock and samples one shared data line
// - left bit captured on falling clock edge, right bit on rising edge
// - density clock programmable from 62.5 kHz to 3.125 MHz
// - density clock can be switched off for microphone sleep
// - density output: two channels stereo or one channel mono with channel select
package arcp_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_HZ         = 25000000;
    localparam int unsigned RATE_MIN_HZ    = 62500;
    localparam int unsigned RATE_MAX_HZ    = 16000000;
    localparam int unsigned DCLK_MIN_HZ    = 62500;
    localparam int unsigned DCLK_MAX_HZ    = 4000000;
    localparam int unsigned FRAME_MIN_HZ   = 8000;
    localparam int unsigned FRAME_MAX_HZ   = 192000;

    localparam logic [15:0] RATE_PER_MIN   = 16'((CLK_HZ + RATE_MAX_HZ - 1) / RATE_MAX_HZ);
    localparam logic [15:0] RATE_PER_MAX   = 16'(CLK_HZ / RATE_MIN_HZ);
    localparam logic [15:0] DCLK_HALF_MIN  = 16'((CLK_HZ + 2 * DCLK_MAX_HZ - 1) / (2 * DCLK_MAX_HZ));
    localparam logic [15:0] DCLK_HALF_MAX  = 16'(CLK_HZ / (2 * DCLK_MIN_HZ));
    localparam logic [15:0] FRAME_PER_MIN  = 16'((CLK_HZ + FRAME_MAX_HZ - 1) / FRAME_MAX_HZ);
    localparam logic [15:0] FRAME_PER_MAX  = 16'(CLK_HZ / FRAME_MIN_HZ);

    // ==========================================================
    // data widths and decimation
    localparam int unsigned SAMPLE_W       = 24;
    localparam int unsigned PAD_W          = 8;
    localparam logic [5:0]  DECIM_LAST     = 6'h3f;
    localparam logic [7:0]  DECIM_MID      = 8'h20;
    localparam int unsigned DECIM_PAD_W    = 17;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0]  ADDR_ROUTE     = 8'h00;
    localparam logic [7:0]  ADDR_CTRL      = 8'h04;
    localparam logic [7:0]  ADDR_IN_RATE   = 8'h08;
    localparam logic [7:0]  ADDR_OUT_RATE  = 8'h0c;
    localparam logic [7:0]  ADDR_IN_LEFT   = 8'h10;
    localparam logic [7:0]  ADDR_IN_RIGHT  = 8'h14;
    localparam logic [7:0]  ADDR_OUT_LEFT  = 8'h18;
    localparam logic [7:0]  ADDR_OUT_RIGHT = 8'h1c;
    localparam logic [7:0]  ADDR_DCLK      = 8'h20;
    localparam logic [7:0]  ADDR_FRAME     = 8'h24;
    localparam logic [7:0]  ADDR_STATUS    = 8'h28;

    // ==========================================================
    // field positions
    localparam int unsigned RT_IN_REGS     = 0;
    localparam int unsigned RT_IN_DENSITY  = 1;
    localparam int unsigned RT_OUT_PCM     = 2;
    localparam int unsigned RT_DMO_DECIM   = 3;
    localparam int unsigned CT_IN_AUTO     = 0;
    localparam int unsigned CT_OUT_AUTO    = 1;
    localparam int unsigned CT_STEREO      = 2;
    localparam int unsigned CT_DCLK_EN     = 3;
    localparam int unsigned CT_DMO_SEL_R   = 4;
    localparam int unsigned CT_DMO_STEREO  = 5;
    localparam int unsigned CT_DMA_EN      = 6;

    // ==========================================================
    // reset values
    localparam logic [3:0]  RST_ROUTE      = 4'h0;
    localparam logic [6:0]  RST_CTRL       = 7'h00;
    localparam logic [15:0] RST_RATE       = RATE_PER_MAX;
    localparam logic [7:0]  RST_DCLK       = 8'h0c;
    localparam logic [11:0] RST_FRAME      = 12'h209;

endpackage

// ===== arcp_decimator.sv
`timescale 1ns/10ps
module arcp_decimator
    import arcp_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                bit_valid,
    input  wire logic                bit_in,
    output logic [SAMPLE_W-1:0]      word_out,
    output logic                     word_valid
);

    logic [5:0] count_ff;
    logic [6:0] ones_ff;
    logic [7:0] total;
    logic [7:0] centred;

    assign total   = {1'b0, ones_ff} + {7'h00, bit_in};
    assign centred = total - DECIM_MID;

    // ==========================================================
    // integrate and dump over one decimation window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_ff   <= 6'h00;
            ones_ff    <= 7'h00;
            word_out   <= 24'h000000;
            word_valid <= 1'b0;
        end else begin
            word_valid <= 1'b0;
            if (bit_valid) begin
                if (count_ff == DECIM_LAST) begin
                    count_ff   <= 6'h00;
                    ones_ff    <= 7'h00;
                    word_out   <= {centred[6:0], {DECIM_PAD_W{1'b0}}};
                    word_valid <= 1'b1;
                end else begin
                    count_ff <= count_ff + 6'h01;
                    ones_ff  <= total[6:0];
                end
            end
        end
    end

endmodule

// ===== arcp_rate_converter.sv
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module arcp_rate_converter
    import arcp_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic [SAMPLE_W-1:0] pcm_in_left,
    input  wire logic [SAMPLE_W-1:0] pcm_in_right,
    input  wire logic                pcm_in_valid,
    input  wire logic                frame_sync,
    output logic [SAMPLE_W-1:0]      pcm_out_left,
    output logic [SAMPLE_W-1:0]      pcm_out_right,
    output logic                     pcm_out_valid,
    output logic                     density_mod_clock,
    input  wire logic                density_mod_data_in,
    output logic                     density_mod_output,
    output logic                     input_conversion_irq,
    output logic                     output_conversion_irq,
    output logic                     input_dma_req,
    output logic                     output_dma_req
);

    // ==========================================================
    // declarations
    logic [3:0]          route_ff;
    logic [6:0]          ctrl_ff;
    logic [15:0]         in_rate_ff;
    logic [15:0]         out_rate_ff;
    logic [7:0]          dclk_half_ff;
    logic [11:0]         frame_per_ff;
    logic [SAMPLE_W-1:0] in_reg_l_ff;
    logic [SAMPLE_W-1:0] in_reg_r_ff;
    logic                wr_l_ff;
    logic                wr_r_ff;
    logic [SAMPLE_W-1:0] pcm_l_ff;
    logic [SAMPLE_W-1:0] pcm_r_ff;
    logic [SAMPLE_W-1:0] hold_l_ff;
    logic [SAMPLE_W-1:0] hold_r_ff;
    logic [SAMPLE_W-1:0] out_l_ff;
    logic [SAMPLE_W-1:0] out_r_ff;
    logic                out_full_ff;
    logic                in_irq_ff;
    logic                out_irq_ff;
    logic                pcm_valid_ff;
    logic                dph_wr_ff;
    logic [7:0]          dph_addr_ff;
    logic [31:0]         hrdata_ff;
    logic [31:0]         nxt_rdata;
    logic                fs_s1_ff;
    logic                fs_s2_ff;
    logic                fs_s3_ff;
    logic                di_s1_ff;
    logic                di_s2_ff;
    logic [7:0]          dclk_cnt_ff;
    logic                dclk_ff;
    logic [SAMPLE_W:0]   acc_ff [2];
    logic                dmo_ff;
    logic [15:0]         tick_per [3];
    logic [2:0]          tick;
    logic                addr_phase;
    logic                wr_en;
    logic                rd_take;
    logic                fs_rise;
    logic                in_take;
    logic                out_take;
    logic                dclk_toggle;
    logic                dclk_rise;
    logic                dclk_fall;
    logic [15:0]         dclk_half;
    logic [SAMPLE_W-1:0] dec_l;
    logic [SAMPLE_W-1:0] dec_r;
    logic [SAMPLE_W-1:0] aud_l;
    logic [SAMPLE_W-1:0] aud_r;
    logic [SAMPLE_W-1:0] mod_src [2];
    logic                take_l;
    logic                take_r;
    logic                step_ch;
    logic                step_en;

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // ==========================================================
    // bus slave
    assign addr_phase = hsel & hready & htrans[1];
    assign rd_take    = addr_phase & ~hwrite;
    assign wr_en      = dph_wr_ff;
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = hrdata_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr_ff   <= 1'b0;
            dph_addr_ff <= 8'h00;
        end else begin
            dph_wr_ff   <= addr_phase & hwrite;
            dph_addr_ff <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
        end
    end

    always_comb begin
        nxt_rdata = 32'h00000000;
        if (haddr[31:8] == 24'h000000) begin
            unique case (haddr[7:0])
                ADDR_ROUTE:     nxt_rdata = {28'h0000000, route_ff};
                ADDR_CTRL:      nxt_rdata = {25'h0000000, ctrl_ff};
                ADDR_IN_RATE:   nxt_rdata = {16'h0000, in_rate_ff};
                ADDR_OUT_RATE:  nxt_rdata = {16'h0000, out_rate_ff};
                ADDR_IN_LEFT:   nxt_rdata = {in_reg_l_ff, 8'h00};
                ADDR_IN_RIGHT:  nxt_rdata = {in_reg_r_ff, 8'h00};
                ADDR_OUT_LEFT:  nxt_rdata = {out_l_ff, 8'h00};
                ADDR_OUT_RIGHT: nxt_rdata = {out_r_ff, 8'h00};
                ADDR_DCLK:      nxt_rdata = {24'h000000, dclk_half_ff};
                ADDR_FRAME:     nxt_rdata = {20'h00000, frame_per_ff};
                ADDR_STATUS:    nxt_rdata = {28'h0000000, dclk_ff, out_full_ff, wr_r_ff, wr_l_ff};
                default:        nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h00000000;
        end else if (rd_take) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            route_ff     <= RST_ROUTE;
            ctrl_ff      <= RST_CTRL;
            in_rate_ff   <= RST_RATE;
            out_rate_ff  <= RST_RATE;
            dclk_half_ff <= RST_DCLK;
            frame_per_ff <= RST_FRAME;
        end else if (wr_en) begin
            unique case (dph_addr_ff)
                ADDR_ROUTE:    route_ff     <= hwdata[3:0];
                ADDR_CTRL:     ctrl_ff      <= hwdata[6:0];
                ADDR_IN_RATE:  in_rate_ff   <= hwdata[15:0];
                ADDR_OUT_RATE: out_rate_ff  <= hwdata[15:0];
                ADDR_DCLK:     dclk_half_ff <= hwdata[7:0];
                ADDR_FRAME:    frame_per_ff <= hwdata[11:0];
                default:       ;
            endcase
        end
    end

    // ==========================================================
    // software input registers, one sample each
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_reg_l_ff <= 24'h000000;
            in_reg_r_ff <= 24'h000000;
        end else if (wr_en) begin
            if (dph_addr_ff == ADDR_IN_LEFT) begin
                in_reg_l_ff <= hwdata[31:PAD_W];
            end
            if (dph_addr_ff == ADDR_IN_RIGHT) begin
                in_reg_r_ff <= hwdata[31:PAD_W];
            end
        end
    end

    // written flags: a write in the cycle of a take keeps the flag set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_l_ff <= 1'b0;
            wr_r_ff <= 1'b0;
        end else begin
            if (wr_en && dph_addr_ff == ADDR_IN_LEFT) begin
                wr_l_ff <= 1'b1;
            end else if (take_l) begin
                wr_l_ff <= 1'b0;
            end
            if (wr_en && dph_addr_ff == ADDR_IN_RIGHT) begin
                wr_r_ff <= 1'b1;
            end else if (take_r) begin
                wr_r_ff <= 1'b0;
            end
        end
    end

    assign input_dma_req = ctrl_ff[CT_DMA_EN] & route_ff[RT_IN_REGS] & ~(wr_l_ff & wr_r_ff);

    // ==========================================================
    // input synchronisers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fs_s1_ff <= 1'b0;
            fs_s2_ff <= 1'b0;
            fs_s3_ff <= 1'b0;
            di_s1_ff <= 1'b0;
            di_s2_ff <= 1'b0;
        end else begin
            fs_s1_ff <= frame_sync;
            fs_s2_ff <= fs_s1_ff;
            fs_s3_ff <= fs_s2_ff;
            di_s1_ff <= density_mod_data_in;
            di_s2_ff <= di_s1_ff;
        end
    end

    assign fs_rise = fs_s2_ff & ~fs_s3_ff;

    // ==========================================================
    // rate tickers: input rate, output rate, main frame counter
    assign tick_per[0] = clamp(in_rate_ff, RATE_PER_MIN, RATE_PER_MAX);
    assign tick_per[1] = clamp(out_rate_ff, RATE_PER_MIN, RATE_PER_MAX);
    assign tick_per[2] = clamp({4'h0, frame_per_ff}, FRAME_PER_MIN, FRAME_PER_MAX);

    for (genvar g = 0; g < 3; g++) begin : g_tick
        logic [15:0] cnt_ff;
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cnt_ff <= 16'h0000;
            end else if (cnt_ff >= tick_per[g] - 16'h0001) begin
                cnt_ff <= 16'h0000;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
        assign tick[g] = (cnt_ff >= tick_per[g] - 16'h0001);
    end

    // ==========================================================
    // input converter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcm_l_ff <= 24'h000000;
            pcm_r_ff <= 24'h000000;
        end else if (pcm_in_valid) begin
            pcm_l_ff <= pcm_in_left;
            pcm_r_ff <= pcm_in_right;
        end
    end

    assign aud_l   = route_ff[RT_IN_DENSITY] ? dec_l : pcm_l_ff;
    assign aud_r   = route_ff[RT_IN_DENSITY] ? dec_r : pcm_r_ff;
    assign in_take = ctrl_ff[CT_IN_AUTO] ? fs_rise : tick[0];

    // stereo waits for both words, mono takes each channel on its own
    assign take_l = in_take & (~route_ff[RT_IN_REGS] |
                    (ctrl_ff[CT_STEREO] ? (wr_l_ff & wr_r_ff) : wr_l_ff));
    assign take_r = in_take & (~route_ff[RT_IN_REGS] |
                    (ctrl_ff[CT_STEREO] ? (wr_l_ff & wr_r_ff) : wr_r_ff));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_l_ff <= 24'h000000;
            hold_r_ff <= 24'h000000;
        end else begin
            if (take_l) begin
                hold_l_ff <= route_ff[RT_IN_REGS] ? in_reg_l_ff : aud_l;
            end
            if (take_r) begin
                hold_r_ff <= route_ff[RT_IN_REGS] ? in_reg_r_ff : aud_r;
            end
        end
    end

    // ==========================================================
    // output converter
    assign out_take = ctrl_ff[CT_OUT_AUTO] ?
                      (route_ff[RT_OUT_PCM] ? fs_rise : tick[2]) : tick[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_l_ff <= 24'h000000;
            out_r_ff <= 24'h000000;
        end else if (out_take) begin
            out_l_ff <= hold_l_ff;
            out_r_ff <= hold_r_ff;
        end
    end

    // full until the right word is read; a new sample wins over the read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_full_ff <= 1'b0;
        end else if (out_take) begin
            out_full_ff <= 1'b1;
        end else if (rd_take && haddr[7:0] == ADDR_OUT_RIGHT && haddr[31:8] == 24'h000000) begin
            out_full_ff <= 1'b0;
        end
    end

    assign output_dma_req = ctrl_ff[CT_DMA_EN] & out_full_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_irq_ff    <= 1'b0;
            out_irq_ff   <= 1'b0;
            pcm_valid_ff <= 1'b0;
        end else begin
            in_irq_ff    <= in_take;
            out_irq_ff   <= out_take;
            pcm_valid_ff <= out_take & route_ff[RT_OUT_PCM];
        end
    end

    assign input_conversion_irq  = in_irq_ff;
    assign output_conversion_irq = out_irq_ff;
    assign pcm_out_valid         = pcm_valid_ff;
    assign pcm_out_left          = out_l_ff;
    assign pcm_out_right         = out_r_ff;

    // ==========================================================
    // density clock generator
    assign dclk_half   = clamp({8'h00, dclk_half_ff}, DCLK_HALF_MIN, DCLK_HALF_MAX);
    assign dclk_toggle = ctrl_ff[CT_DCLK_EN] & ({8'h00, dclk_cnt_ff} >= dclk_half - 16'h0001);
    assign dclk_rise   = dclk_toggle & ~dclk_ff;
    assign dclk_fall   = dclk_toggle & dclk_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dclk_cnt_ff <= 8'h00;
            dclk_ff     <= 1'b0;
        end else if (!ctrl_ff[CT_DCLK_EN]) begin
            dclk_cnt_ff <= 8'h00;
            dclk_ff     <= 1'b0;
        end else if (dclk_toggle) begin
            dclk_cnt_ff <= 8'h00;
            dclk_ff     <= ~dclk_ff;
        end else begin
            dclk_cnt_ff <= dclk_cnt_ff + 8'h01;
        end
    end

    assign density_mod_clock = dclk_ff;

    // ==========================================================
    // density input capture and decimation
    arcp_decimator u_dec_left (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .bit_valid  (dclk_fall),
        .bit_in     (di_s2_ff),
        .word_out   (dec_l),
        .word_valid ()
    );

    arcp_decimator u_dec_right (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .bit_valid  (dclk_rise),
        .bit_in     (di_s2_ff),
        .word_out   (dec_r),
        .word_valid ()
    );

    // ==========================================================
    // density output modulator
    assign mod_src[0] = route_ff[RT_DMO_DECIM] ? dec_l : hold_l_ff;
    assign mod_src[1] = route_ff[RT_DMO_DECIM] ? dec_r : hold_r_ff;
    assign step_en    = dclk_rise | dclk_fall;
    assign step_ch    = ctrl_ff[CT_DMO_STEREO] ? ctrl_ff[CT_DMO_SEL_R] : dclk_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff[0] <= 25'h0000000;
            acc_ff[1] <= 25'h0000000;
            dmo_ff    <= 1'b0;
        end else if (step_en) begin
            for (int c = 0; c < 2; c++) begin
                if (step_ch == c[0]) begin
                    acc_ff[c] <= {1'b0, acc_ff[c][SAMPLE_W-1:0]} +
                                 {1'b0, mod_src[c] ^ 24'h800000};
                end
            end
            dmo_ff <= acc_ff[step_ch][SAMPLE_W];
        end
    end

    assign density_mod_output = dmo_ff;

endmodule

// ===== arcp_monitor.sv
`timescale 1ns/10ps
module arcp_monitor (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [23:0] pcm_out_left,
    input wire logic [23:0] pcm_out_right,
    input wire logic        pcm_out_valid,
    input wire logic        density_mod_clock,
    input wire logic        input_conversion_irq,
    input wire logic        output_conversion_irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // conversion events
    in_pulse_a: assert property (input_conversion_irq |=> !input_conversion_irq)
        else $error("input irq longer than one cycle");
    out_pulse_a: assert property (output_conversion_irq |=> !output_conversion_irq)
        else $error("output irq longer than one cycle");
    pcm_with_irq_a: assert property (pcm_out_valid |-> output_conversion_irq)
        else $error("pcm valid without conversion");
    left_hold_a: assert property (!output_conversion_irq |-> $stable(pcm_out_left))
        else $error("left word moved without conversion");
    right_hold_a: assert property (!output_conversion_irq |-> $stable(pcm_out_right))
        else $error("right word moved without conversion");
    // ==========================================================
    // density clock and bus
    clk_low_a: assert property ($fell(density_mod_clock) |=> (!density_mod_clock)[*3])
        else $error("density clock low too short");
    clk_high_a: assert property ($rose(density_mod_clock) |-> ##[1:200] $fell(density_mod_clock))
        else $error("density clock high too long");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus wait or error response");
endmodule

// ===== arcp_mic_pair.sv
`timescale 1ns/10ps
module arcp_mic_pair (
    input  wire logic density_mod_clock,
    output logic      density_mod_data_in
);
    // left mic sends ones while clock high, right mic zeros while low
    assign density_mod_data_in = density_mod_clock;
endmodule

// ===== tb_audio_rate_converter_pdm.sv
`timescale 1ns/10ps
module tb_audio_rate_converter_pdm;
    import arcp_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_ph;
    logic [31:0] haddr, hwdata, hrdata, l, r;
    logic [23:0] pcm_in_left, pcm_in_right, pcm_out_left, pcm_out_right;
    logic [2:0]  hsize;
    logic [1:0]  htrans;
    logic        pcm_in_valid, frame_sync, pcm_out_valid, density_mod_clock;
    logic        density_mod_data_in, density_mod_output, input_dma_req, output_dma_req;
    logic        input_conversion_irq, output_conversion_irq;
    logic [31:0] q[$];
    int          fails, num_checks, n, c;
    assign hready = hreadyout;
    arcp_rate_converter dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pcm_in_left, .pcm_in_right,
        .pcm_in_valid, .frame_sync, .pcm_out_left, .pcm_out_right, .pcm_out_valid,
        .density_mod_clock, .density_mod_data_in, .density_mod_output,
        .input_conversion_irq, .output_conversion_irq, .input_dma_req, .output_dma_req);
    arcp_mic_pair mic_u (.density_mod_clock, .density_mod_data_in);
    // ==========================================================
    // checking and bus tasks
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wev(input bit o);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((o ? output_conversion_irq : input_conversion_irq) !== 1'b1 && n < 3000);
        if (n >= 3000) fails++;
    endtask
    always @(posedge hclk) if (rd_ph && hready) chk("rdata", hrdata, q.pop_front());
    initial begin
        hclk = 0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        #1000000 fails++;
        wrap_up();
    end
    // ==========================================================
    // scenarios
    initial begin
        {hresetn, hwrite, rd_ph, pcm_in_valid, frame_sync, htrans} = 0;
        {haddr, hwdata, pcm_in_left, pcm_in_right} = 0;
        hsel = 1;
        hsize = 3'h2;
        void'($urandom(32'h76ff));
        repeat (16) @(posedge hclk);
        hresetn <= 1;
        rd(ADDR_ROUTE, 0);
        rd(ADDR_CTRL, 0);
        rd(ADDR_IN_RATE, 32'h190);
        rd(8'h2c, 0);
        for (int i = 0; i < 2; i++) begin
            bus(1, ADDR_IN_RATE, i ? 23 : 10);
            wev(0);
            wev(0);
            chk("pace", n, i ? 23 : 10);
        end
        bus(1, ADDR_CTRL, 1);
        c = 0;
        repeat (40) begin
            @(posedge hclk);
            c += input_conversion_irq;
        end
        frame_sync <= 1;
        wev(0);
        chk("auto idle", c, 0);
        chk("auto lag", n <= 8, 1);
        bus(1, ADDR_IN_RATE, 2);
        bus(1, ADDR_OUT_RATE, 2);
        bus(1, ADDR_CTRL, 32'h44);
        bus(1, ADDR_ROUTE, 5);
        l = $urandom;
        r = $urandom;
        bus(1, ADDR_IN_LEFT, l);
        chk("in dma", input_dma_req, 1);
        bus(1, ADDR_IN_RIGHT, r);
        wev(0);
        wev(1);
        wev(1);
        chk("out dma", output_dma_req, 1);
        rd(ADDR_OUT_LEFT, {l[31:8], 8'h0});
        rd(ADDR_OUT_RIGHT, {r[31:8], 8'h0});
        chk("pcm", pcm_out_left, l[31:8]);
        bus(1, ADDR_ROUTE, 4);
        pcm_in_left <= 24'($urandom);
        pcm_in_right <= 24'($urandom);
        pcm_in_valid <= 1;
        repeat (2) wev(0);
        repeat (2) wev(1);
        chk("pcm in", pcm_out_left, pcm_in_left);
        chk("pcm in r", pcm_out_right, pcm_in_right);
        bus(1, ADDR_FRAME, 625);
        bus(1, ADDR_CTRL, 2);
        bus(1, ADDR_ROUTE, 0);
        wev(1);
        wev(1);
        chk("frame", n, 625);
        bus(1, ADDR_DCLK, 4);
        bus(1, ADDR_CTRL, 8);
        bus(1, ADDR_ROUTE, 2);
        repeat (3000) @(posedge hclk);
        rd(ADDR_OUT_LEFT, 32'h40000000);
        rd(ADDR_OUT_RIGHT, 32'hc0000000);
        bus(1, ADDR_CTRL, 0);
        repeat (20) @(posedge hclk);
        chk("clk off", density_mod_clock, 0);
        wrap_up();
    end
endmodule
bind arcp_rate_converter arcp_monitor mon_u (.hclk, .hresetn, .hreadyout, .hresp,
    .pcm_out_left, .pcm_out_right, .pcm_out_valid, .density_mod_clock,
    .input_conversion_irq, .output_conversion_irq);
